/* File: src/vic_defines.svh */
// Purpose: constants of the vectored interrupt controller
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes:   offsets are word indices; byte address is four times the index
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define VIC_IDX_INTERRUPT_CONTROL_REGISTER     6'h0B
`define VIC_IDX_EVT_STS  6'h20
`define VIC_IDX_EVT_EN   6'h21
`define VIC_IDX_EVT_CLR  6'h22

// ----------------------------------------------------------------------
// Interrupt control register bit positions
// ----------------------------------------------------------------------
`define VIC_BIT_GIE      0
`define VIC_BIT_EXT_EN   1
`define VIC_BIT_T0_EN    2
`define VIC_BIT_T1_EN    3
`define VIC_BIT_EXT_FLAG 4
`define VIC_BIT_T0_FLAG  5
`define VIC_BIT_T1_FLAG  6
`define VIC_INTERRUPT_CONTROL_REGISTER_RESET   8'h00

// ----------------------------------------------------------------------
// Event status bits, vectors
// ----------------------------------------------------------------------
`define VIC_EVT_EXT      0
`define VIC_EVT_T0       1
`define VIC_EVT_T1       2
`define VIC_EVT_BLOCKED  3
`define VIC_EVT_W        4
`define VIC_VEC_EXT      8'h04
`define VIC_VEC_T0       8'h08
`define VIC_VEC_T1       8'h0C
`define VIC_VEC_NONE     8'h00

`endif

/* File: src/vic_pkg.sv */
// Purpose: types of the vectored interrupt controller
// Assumes: constants come from vic_defines.svh
// Notes:   whole module state is one packed struct
`include "vic_defines.svh"

package vic_pkg;

  // Source chosen by the arbiter
  typedef enum logic [1:0] {
    VIC_SRC_NONE = 2'b00,
    VIC_SRC_EXT  = 2'b01,
    VIC_SRC_T0   = 2'b10,
    VIC_SRC_T1   = 2'b11
  } vic_src_t;

  // Complete register state of the controller
  typedef struct packed {
    logic                  ext_prev;
    logic                  t2_prev;
    logic                  gie;
    logic                  ext_en;
    logic                  t0_en;
    logic                  t1_en;
    logic                  ext_flag;
    logic                  t0_flag;
    logic                  t1_flag;
    logic [`VIC_EVT_W-1:0] evt_sts;
    logic [`VIC_EVT_W-1:0] evt_en;
    logic                  wr_pend;
    logic [5:0]            wr_idx;
    logic [31:0]           rdata;
    logic                  call;
    logic [7:0]            vector;
  } vic_state_t;

endpackage : vic_pkg

/* File: src/vic_top.sv */
// Purpose: vectored interrupt controller with AHB-Lite register access
// Assumes: all inputs synchronous to hclk; core gives phase and stack status
// Notes:   zero-wait-state slave, response always OKAY
//
// Function
// [R1] Falling edge on external input sets external request flag, bit 4.
// [R2] Pending, enabled external request with global enable and room calls 04H.
// [R3] External acknowledge clears its flag and the global enable.
// [R4] Timer 0 overflow sets timer 0 request flag, bit 5.
// [R5] Enabled timer 0 request calls 08H; clears its flag and global enable.
// [R6] Two-timer variant: enabled timer 1 request calls 0CH.
// [R7] Simultaneous requests served external first, then timer 0, timer 1.
// [R8] Full stack keeps requests latched, unacknowledged until a return.
// [R9] Acknowledges held until interrupt return or software re-enables nesting.
// [R10] Interrupt return sets global enable; plain return leaves it alone.
// [R11] Request between two phase-two pulses served at the second one.
// [R12] Global enable cleared masks every source.
// [R13] Request flags stay set until serviced or cleared by software.
// [R14] Acknowledge pushes only the program counter and branches to vector.
// [R15] Every source can wake the device from power-down.
// [R16] Enables at bits 0 global, 1 external, 2 timer 0, 3 timer 1.
// [R17] Single-timer variant: bits 3, 6 and 7 read as zero.
// [R18] Two-timer variant: timer 1 request flag at bit 6.
// [R19] Software writes load request flag bits directly.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.svh"

module vic_top #(
  parameter bit DUAL_TIMER = 1'b1           // Second timer present
) (
  input  wire logic        hclk,            // System clock
  input  wire logic        hresetn,         // Async reset, active low
  input  wire logic        hsel,            // Slave select
  input  wire logic [31:0] haddr,           // Byte address
  input  wire logic [1:0]  htrans,          // Transfer type
  input  wire logic        hwrite,          // Write when high
  input  wire logic [2:0]  hsize,           // Transfer size
  input  wire logic [31:0] hwdata,          // Write data
  input  wire logic        hready,          // Bus ready
  output logic      [31:0] hrdata,          // Read data
  output logic             hreadyout,       // Slave ready
  output logic             hresp,           // Response, OKAY
  input  wire logic        ext_irq_n,       // External interrupt pin level
  input  wire logic        timer_zero_ovf,  // Timer 0 overflow pulse
  input  wire logic        timer_one_ovf,   // Timer 1 overflow pulse
  input  wire logic        phase_two_pulse, // Machine-cycle phase two
  input  wire logic        stack_full,      // Core stack is full
  input  wire logic        return_from_interrupt_exec,       // Interrupt return executes
  input  wire logic        ret_exec,        // Plain return executes
  output logic             call_req,        // Vector call pulse
  output logic      [7:0]  call_vector,     // Vector address
  output logic             push_pc,         // Push program counter only
  output logic             wake_req,        // Wake from power-down
  output logic             irq              // Event interrupt level
);
  import vic_pkg::*;

  vic_state_t st_reg;
  vic_state_t st_next;
  vic_src_t   pick;
  logic       t2_rise;
  logic       ext_fall;
  logic       t1_ovf;
  logic       ext_req;
  logic       t0_req;
  logic       t1_req;
  logic       any_req;
  logic       addr_ok;
  logic [5:0] a_idx;
  logic [7:0] interrupt_control_register_rd;

  // ----------------------------------------------------------------------
  // Edge detection and request qualification
  // ----------------------------------------------------------------------
  // Inputs are synchronous, so one previous sample is enough
  assign ext_fall = st_reg.ext_prev & ~ext_irq_n;       // R1
  assign t2_rise  = phase_two_pulse & ~st_reg.t2_prev;  // R11
  assign t1_ovf   = DUAL_TIMER & timer_one_ovf;         // R6

  // Global enable gates all; full stack holds every request off
  assign ext_req = st_reg.gie & st_reg.ext_en & st_reg.ext_flag; // R2 R12
  assign t0_req  = st_reg.gie & st_reg.t0_en & st_reg.t0_flag;   // R5 R12
  assign t1_req  = DUAL_TIMER & st_reg.gie & st_reg.t1_en
                   & st_reg.t1_flag;                             // R6 R12
  assign any_req = ext_req | t0_req | t1_req;

  // Fixed priority arbiter
  always_comb begin
    if (!t2_rise || stack_full) begin     // R8 R11
      pick = VIC_SRC_NONE;
    end else if (ext_req) begin           // R7
      pick = VIC_SRC_EXT;
    end else if (t0_req) begin            // R7
      pick = VIC_SRC_T0;
    end else if (t1_req) begin            // R7
      pick = VIC_SRC_T1;
    end else begin
      pick = VIC_SRC_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Bus address decode
  // ----------------------------------------------------------------------
  assign a_idx   = haddr[7:2];
  assign addr_ok = hsel & htrans[1] & hready;

  // Read view of the control register; absent bits read zero
  always_comb begin
    interrupt_control_register_rd = 8'h00;
    interrupt_control_register_rd[`VIC_BIT_GIE]      = st_next.gie;            // R16
    interrupt_control_register_rd[`VIC_BIT_EXT_EN]   = st_next.ext_en;         // R16
    interrupt_control_register_rd[`VIC_BIT_T0_EN]    = st_next.t0_en;          // R16
    interrupt_control_register_rd[`VIC_BIT_EXT_FLAG] = st_next.ext_flag;
    interrupt_control_register_rd[`VIC_BIT_T0_FLAG]  = st_next.t0_flag;
    if (DUAL_TIMER) begin
      interrupt_control_register_rd[`VIC_BIT_T1_EN]   = st_next.t1_en;         // R16
      interrupt_control_register_rd[`VIC_BIT_T1_FLAG] = st_next.t1_flag;       // R18
    end                                                  // R17
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Order matters: bus write, then returns, then acknowledge,
  // then hardware sets last so an event is never lost to a clear
  always_comb begin
    st_next          = st_reg;
    st_next.ext_prev = ext_irq_n;
    st_next.t2_prev  = phase_two_pulse;
    st_next.call     = 1'b0;
    st_next.wr_pend  = 1'b0;

    // Data phase of a posted write
    if (st_reg.wr_pend) begin
      if (st_reg.wr_idx == `VIC_IDX_INTERRUPT_CONTROL_REGISTER) begin
        st_next.gie      = hwdata[`VIC_BIT_GIE];
        st_next.ext_en   = hwdata[`VIC_BIT_EXT_EN];
        st_next.t0_en    = hwdata[`VIC_BIT_T0_EN];
        st_next.ext_flag = hwdata[`VIC_BIT_EXT_FLAG];    // R19
        st_next.t0_flag  = hwdata[`VIC_BIT_T0_FLAG];     // R19
        st_next.t1_en    = DUAL_TIMER & hwdata[`VIC_BIT_T1_EN];
        st_next.t1_flag  = DUAL_TIMER & hwdata[`VIC_BIT_T1_FLAG]; // R18 R19
      end else if (st_reg.wr_idx == `VIC_IDX_EVT_EN) begin
        st_next.evt_en = hwdata[`VIC_EVT_W-1:0];
      end else if (st_reg.wr_idx == `VIC_IDX_EVT_CLR) begin
        st_next.evt_sts = st_reg.evt_sts & ~hwdata[`VIC_EVT_W-1:0];
      end
    end

    // Interrupt return reopens acknowledges; plain return does not
    if (return_from_interrupt_exec) begin
      st_next.gie = 1'b1;                                // R9 R10
    end

    // Acknowledge: clear source flag and global enable
    case (pick)
      VIC_SRC_EXT: begin
        st_next.ext_flag = 1'b0;                         // R3
        st_next.gie      = 1'b0;                         // R3 R9
        st_next.call     = 1'b1;
        st_next.vector   = `VIC_VEC_EXT;                 // R2
      end
      VIC_SRC_T0: begin
        st_next.t0_flag = 1'b0;                          // R5
        st_next.gie     = 1'b0;                          // R5 R9
        st_next.call    = 1'b1;
        st_next.vector  = `VIC_VEC_T0;                   // R5
      end
      VIC_SRC_T1: begin
        st_next.t1_flag = 1'b0;
        st_next.gie     = 1'b0;                          // R9
        st_next.call    = 1'b1;
        st_next.vector  = `VIC_VEC_T1;                   // R6
      end
      default: begin
      end
    endcase

    // Hardware sets win over any clear in the same cycle
    if (ext_fall) begin
      st_next.ext_flag = 1'b1;                           // R1 R13
      st_next.evt_sts[`VIC_EVT_EXT] = 1'b1;
    end
    if (timer_zero_ovf) begin
      st_next.t0_flag = 1'b1;                            // R4 R13
      st_next.evt_sts[`VIC_EVT_T0] = 1'b1;
    end
    if (t1_ovf) begin
      st_next.t1_flag = 1'b1;                            // R13
      st_next.evt_sts[`VIC_EVT_T1] = 1'b1;
    end
    if (t2_rise && stack_full && any_req) begin
      st_next.evt_sts[`VIC_EVT_BLOCKED] = 1'b1;          // R8
    end

    // Address phase: capture writes, prepare read data
    if (addr_ok) begin
      st_next.wr_pend = hwrite;
      st_next.wr_idx  = a_idx;
      if (!hwrite) begin
        if (a_idx == `VIC_IDX_INTERRUPT_CONTROL_REGISTER) begin
          st_next.rdata = {24'h000000, interrupt_control_register_rd};
        end else if (a_idx == `VIC_IDX_EVT_STS) begin
          st_next.rdata = {28'h0000000, st_next.evt_sts};
        end else if (a_idx == `VIC_IDX_EVT_EN) begin
          st_next.rdata = {28'h0000000, st_next.evt_en};
        end else begin
          st_next.rdata = 32'h00000000;  // Unmapped and write-only
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg          <= '0;
      st_reg.ext_prev <= 1'b1;  // Pin idles high; no false edge
      {st_reg.t1_flag, st_reg.t0_flag, st_reg.ext_flag,
       st_reg.t1_en, st_reg.t0_en, st_reg.ext_en,
       st_reg.gie} <= 7'(`VIC_INTERRUPT_CONTROL_REGISTER_RESET);
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hrdata      = st_reg.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign call_req    = st_reg.call;
  assign push_pc     = st_reg.call;    // R14
  assign call_vector = st_reg.vector;  // R14
  // Wake ignores global enable so a masked source still wakes
  assign wake_req    = (st_reg.ext_flag & st_reg.ext_en)
                     | (st_reg.t0_flag & st_reg.t0_en)
                     | (DUAL_TIMER & st_reg.t1_flag & st_reg.t1_en); // R15
  assign irq         = |(st_reg.evt_sts & st_reg.evt_en);

  // Plain return has no effect on the global enable
  logic unused_ok;
  assign unused_ok = &{1'b0, ret_exec, hsize, haddr[31:8], haddr[1:0]}; // R10

endmodule : vic_top
`default_nettype wire

/* File: tb/vic_core_model.sv */
// Purpose: core sequencer and stack model
// Assumes: one push per call, pops on request
// Notes:   phase two rises every 4 cycles
`timescale 1ns/1ps
`default_nettype none
module vic_core_model #(
  parameter int DEPTH = 2                 // Stack levels
) (
  input  wire logic hclk,                 // Clock
  input  wire logic hresetn,              // Reset, active low
  input  wire logic push_pc,              // Call pushes
  input  wire logic pop_req,              // Return requested
  input  wire logic pop_return_from_interrupt,             // Return kind
  output logic      phase_two_pulse,      // Phase two
  output logic      stack_full,           // No room left
  output logic      return_from_interrupt_exec,            // Interrupt return
  output logic      ret_exec              // Plain return
);
  logic [1:0] ph_reg;
  int         dep_reg;
  // Phase counter and stack depth
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg  <= 2'h0;
      dep_reg <= 0;
    end else begin
      ph_reg  <= ph_reg + 2'h1;
      dep_reg <= dep_reg + int'(push_pc) - int'(pop_req);
    end
  end
  assign phase_two_pulse = (ph_reg == 2'h3);
  assign stack_full = (dep_reg >= DEPTH);
  assign return_from_interrupt_exec = pop_req & pop_return_from_interrupt;
  assign ret_exec = pop_req & ~pop_return_from_interrupt;
endmodule : vic_core_model
`default_nettype wire

/* File: tb/vic_top_asserts.sv */
// Purpose: port checker of the controller
// Assumes: single clock domain
// Notes:   bound into every vic_top
`timescale 1ns/1ps
`default_nettype none
module vic_top_chk (
  input wire logic       hclk,            // Clock
  input wire logic       hresetn,         // Reset
  input wire logic       hreadyout,       // Slave ready
  input wire logic       hresp,           // Response
  input wire logic       phase_two_pulse, // Phase two
  input wire logic       stack_full,      // Stack full
  input wire logic       call_req,        // Call pulse
  input wire logic       push_pc,         // Push
  input wire logic [7:0] call_vector,     // Vector
  input wire logic       wake_req         // Wake
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_call_on_phase: assert property (call_req |-> $past(phase_two_pulse) &&
    !$past(phase_two_pulse, 2)) else $error("call off phase edge");
  a_full_blocks: assert property (call_req |-> !$past(stack_full))
    else $error("call with full stack");
  a_call_once: assert property (call_req |=> !call_req)
    else $error("call longer than a cycle");
  a_push_only: assert property (push_pc == call_req)
    else $error("push differs from call");
  a_vec_legal: assert property (call_req |-> call_vector inside {8'h04, 8'h08, 8'h0C})
    else $error("bad vector");
  a_vec_hold: assert property (!call_req |-> $stable(call_vector))
    else $error("vector moved");
  a_wake_first: assert property (call_req |-> $past(wake_req))
    else $error("call without wake");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule : vic_top_chk
bind vic_top vic_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .phase_two_pulse(phase_two_pulse), .stack_full(stack_full),
  .call_req(call_req), .push_pc(push_pc), .call_vector(call_vector), .wake_req(wake_req));
`default_nettype wire

/* File: tb/vic_top_tb.sv */
// Purpose: self-checking bench of the controller
// Assumes: dual timer, stack of two
// Notes:   control at 0x2C, events 0x80..0x88
`timescale 1ns/1ps
`default_nettype none
module vic_top_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_n = 1, t0 = 0, t1 = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [7:0] vec;
  logic rdy, resp, ph, full, return_from_interrupt, ret, call, push, wake, irq, pop = 0, popk = 0;
  int err_total = 0, n_checks = 0;
  always #25 hclk = ~hclk;
  vic_top u_vic_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(resp), .ext_irq_n(ext_n),
    .timer_zero_ovf(t0), .timer_one_ovf(t1), .phase_two_pulse(ph), .stack_full(full),
    .return_from_interrupt_exec(return_from_interrupt), .ret_exec(ret), .call_req(call), .call_vector(vec),
    .push_pc(push), .wake_req(wake), .irq(irq));
  vic_core_model u_vic_core_model (.hclk(hclk), .hresetn(hresetn), .push_pc(push),
    .pop_req(pop), .pop_return_from_interrupt(popk), .phase_two_pulse(ph), .stack_full(full),
    .return_from_interrupt_exec(return_from_interrupt), .ret_exec(ret));
  task results;
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %0t got %h want %h", $time, g, e);
      err_total++;
    end
  endtask : chk
  task fail;
    $display("unexpected %0t wait ran out", $time);
    err_total++;
    results();
  endtask : fail
  // One bus phase: wait for ready under a bound
  task step;
    int i;
    i = 0;
    do begin @(posedge hclk); i++; end while (rdy !== 1'b1 && i < 50);
    if (rdy !== 1'b1) fail();
  endtask : step
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    step();
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    step();
    q = hrdata;
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task wait_call(input logic [7:0] v);
    int i;
    for (i = 0; i < 40; i++) begin @(posedge hclk); #1; if (call === 1'b1) break; end
    if (i >= 40) fail();
    chk({24'h0, vec}, {24'h0, v});
  endtask : wait_call
  task quiet;
    repeat (16) begin @(posedge hclk); #1; chk({31'h0, call}, 32'h0); end
  endtask : quiet
  task pop_one(input logic k);
    pop <= 1; popk <= k;
    @(posedge hclk);
    pop <= 0;
    @(posedge hclk);
  endtask : pop_one
  // Reset values, flag loading, unused bits
  task s_regs;
    rd(32'h2C, 32'h0);
    rd(32'h40, 32'h0);
    wr(32'h2C, 32'hFFF0);
    rd(32'h2C, 32'h70);
    wr(32'h2C, 32'h0);
    rd(32'h2C, 32'h0);
  endtask : s_regs
  // Sources pending but globally masked; event interrupt
  task s_masked;
    wr(32'h2C, 32'h0E);
    ext_n <= 0; t0 <= 1; t1 <= 1;
    @(posedge hclk);
    t0 <= 0; t1 <= 0;
    quiet();
    chk({31'h0, wake}, 32'h1);
    rd(32'h2C, 32'h7E);
    rd(32'h80, 32'h7);
    wr(32'h84, 32'h7);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wr(32'h88, 32'h7);
    rd(32'h80, 32'h0);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    ext_n <= 1;
  endtask : s_masked
  // Priority, nesting, full stack, returns
  task s_nest;
    wr(32'h2C, 32'h7F);
    wait_call(8'h04);
    rd(32'h2C, 32'h6E);
    quiet();
    wr(32'h2C, 32'h6F);
    wait_call(8'h08);
    rd(32'h2C, 32'h4E);
    wr(32'h2C, 32'h4F);
    quiet();
    rd(32'h2C, 32'h4F);
    rd(32'h80, 32'h8);
    pop_one(1'b0);
    wait_call(8'h0C);
    rd(32'h2C, 32'h0E);
    pop_one(1'b1);
    pop_one(1'b1);
    rd(32'h2C, 32'h0F);
    wr(32'h2C, 32'h0E);
    pop_one(1'b0);
    rd(32'h2C, 32'h0E);
  endtask : s_nest
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    s_regs();
    s_masked();
    s_nest();
    results();
  end
endmodule : vic_top_tb
`default_nettype wire
